// ===== design/pwmc_map.svh
// pwmc_map.svh: offsets, field positions, reset values and keys of the PWM control block.
// assumes a byte-addressed AXI4-Lite slave with 8-bit addresses.
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH
`define PWMC_OFS_TBCTL   8'h00
`define PWMC_OFS_IOCTL   8'h04
`define PWMC_OFS_LEBCTL  8'h08
`define PWMC_OFS_LEBDLY  8'h0c
`define PWMC_OFS_PERIOD  8'h10
`define PWMC_OFS_ACTPER  8'h14
`define PWMC_OFS_UNLOCK  8'h18
`define PWMC_OFS_TBCNT   8'h1c
`define PWMC_TB_EN       15
`define PWMC_TB_IDLE     13
`define PWMC_TB_PEND     12
`define PWMC_TB_SPECIAL_EVENT_IRQ_ENABLE    11
`define PWMC_TB_IMM      10
`define PWMC_TB_SPOL     9
`define PWMC_TB_SOEN     8
`define PWMC_TB_SEN      7
`define PWMC_TBCTL_WMASK 16'hafff
`define PWMC_IOCTL_RST   16'hc000
`define PWMC_LEBCTL_MASK 16'hfc3f
`define PWMC_LEBDLY_MASK 16'h0fff
`define PWMC_UNLOCK_KEY1 16'haa55
`define PWMC_UNLOCK_KEY2 16'h55aa
`define PWMC_RESP_OKAY   2'b00
`define PWMC_RESP_SLVERR 2'b10
`endif

// ===== design/pwmc_pkg.sv
// pwmc_pkg: types shared by the PWM control block and its bench.
// assumes pwmc_map.svh carries all numeric constants.
package pwmc_pkg;
    typedef enum logic [1:0] {
        PM_COMPL    = 2'b00,
        PM_REDUND   = 2'b01,
        PM_PUSHPULL = 2'b10,
        PM_RSVD     = 2'b11
    } pwmc_pin_pair_mode_t;

    typedef enum logic [1:0] {
        UL_LOCKED = 2'b00,
        UL_KEY1   = 2'b01,
        UL_OPEN   = 2'b10
    } pwmc_unlock_t;

    typedef struct packed {
        logic high;
        logic low;
        logic high_oe;
        logic low_oe;
    } pwmc_pins_t;
endpackage

// ===== design/pwmc_top.sv
// pwmc_top: one PWM channel's control, pin pair logic and edge blanking, AXI4-Lite slave.
// assumes gen/event/blank-select inputs come from logic on i_clk; sync, fault and
// current-limit arrive from pins and are synchronised here.
//
// Overview of operation
// [RULE_01] module runs only while enable bit set
// [RULE_02] idle halt bit stops time base in idle
// [RULE_03] event sets pending flag; irq gated by enable
// [RULE_04] period loads now or at cycle boundary
// [RULE_05] sync polarity bit makes sync active low
// [RULE_06] sync output driven only when enabled
// [RULE_07] external sync restarts time base when enabled
// [RULE_08] software changes sync settings only when disabled
// [RULE_09] software sets period above sync period
// [RULE_10] pin pair mode selects output pairing
// [RULE_11] override bits replace generator per pin
// [RULE_12] fault and current limit force data bits
// [RULE_13] software keeps pin mode fixed once enabled
// [RULE_14] locked io control writes need unlock sequence
// [RULE_15] enabled output edges restart blanking counter
// [RULE_16] twelve-bit blanking delay, upper bits zero
// [RULE_17] state blanking on selected signal level
// [RULE_18] state blanking on each output level
// [RULE_19] blanked inputs ignored until delay expires
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_top (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_cpu_idle,
    input  wire logic                 i_config_write_lock,
    input  wire logic                 i_special_event,
    input  wire logic                 i_special_event_ack,
    input  wire logic                 i_gen_high,
    input  wire logic                 i_blank_select,
    input  wire logic                 i_sync_input,
    input  wire logic                 i_fault_input,
    input  wire logic                 i_current_limit_input,
    input  wire logic                 i_s_axi_awvalid,
    output wire logic                 o_s_axi_awready,
    input  wire logic [7:0]           i_s_axi_awaddr,
    input  wire logic                 i_s_axi_wvalid,
    output wire logic                 o_s_axi_wready,
    input  wire logic [31:0]          i_s_axi_wdata,
    input  wire logic [3:0]           i_s_axi_wstrb,
    output wire logic                 o_s_axi_bvalid,
    input  wire logic                 i_s_axi_bready,
    output wire logic [1:0]           o_s_axi_bresp,
    input  wire logic                 i_s_axi_arvalid,
    output wire logic                 o_s_axi_arready,
    input  wire logic [7:0]           i_s_axi_araddr,
    output wire logic                 o_s_axi_rvalid,
    input  wire logic                 i_s_axi_rready,
    output wire logic [31:0]          o_s_axi_rdata,
    output wire logic [1:0]           o_s_axi_rresp,
    output pwmc_pkg::pwmc_pins_t      o_pins,
    output wire logic                 o_sync_output,
    output wire logic                 o_special_event_irq
);
    import pwmc_pkg::*;

    logic [15:0]  tbctl_q, iocon_q, lebcon_q, lebdly_q, period_q, act_period_q, tb_cnt_q;
    logic         pend_q, load_pend_q, phase_q, sync_out_q, sync_prev_q;
    logic         sync_ff1_q, sync_ff2_q, flt_ff1_q, flt_ff2_q, cl_ff1_q, cl_ff2_q;
    logic [11:0]  leb_cnt_q;
    pwmc_unlock_t ul_q;
    pwmc_pins_t   pins_q, pins_d;
    logic         aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [1:0]   bresp_q, rresp_q;
    logic [7:0]   awaddr_q;
    logic [15:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic [31:0]  rdata_q, rd_word;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [3:0] strb, input logic [15:0] msk);
        logic [15:0] r;
        r = old;
        if (strb[0]) r[7:0] = nw[7:0];
        if (strb[1]) r[15:8] = nw[15:8];
        return r & msk;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a[7:5] == 3'b000;
    endfunction

    function automatic logic [31:0] zext16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // field decode
    logic       en, idle_halt, special_event_irq_enable, imm, pol, oen, ext_en;
    logic       high_pin_ownership, low_pin_ownership, high_pin_polarity, poll, ovr_h, ovr_l;
    pwmc_pin_pair_mode_t pin_pair_mode;
    assign en        = tbctl_q[`PWMC_TB_EN];
    assign idle_halt = tbctl_q[`PWMC_TB_IDLE];
    assign special_event_irq_enable     = tbctl_q[`PWMC_TB_SPECIAL_EVENT_IRQ_ENABLE];
    assign imm       = tbctl_q[`PWMC_TB_IMM];
    assign pol       = tbctl_q[`PWMC_TB_SPOL];
    assign oen       = tbctl_q[`PWMC_TB_SOEN];
    assign ext_en    = tbctl_q[`PWMC_TB_SEN];
    assign high_pin_ownership      = iocon_q[15];
    assign low_pin_ownership      = iocon_q[14];
    assign high_pin_polarity      = iocon_q[13];
    assign poll      = iocon_q[12];
    assign pin_pair_mode      = pwmc_pin_pair_mode_t'(iocon_q[11:10]);
    assign ovr_h     = iocon_q[9];
    assign ovr_l     = iocon_q[8];

    ////////////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order
    logic do_wr, wr_tb, wr_io, wr_lc, wr_ld, wr_per, wr_key, io_open;
    logic [15:0] per_new;
    assign o_s_axi_awready = !aw_hold_q && !bvalid_q;
    assign o_s_axi_wready  = !w_hold_q && !bvalid_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign do_wr  = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_tb  = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_TBCTL);
    assign wr_io  = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_IOCTL);
    assign wr_lc  = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_LEBCTL);
    assign wr_ld  = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_LEBDLY);
    assign wr_per = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_PERIOD);
    assign wr_key = do_wr && ({awaddr_q[7:2], 2'b00} == `PWMC_OFS_UNLOCK);
    assign per_new = merge16(period_q, wdata_q, wstrb_q, 16'hffff);
    assign io_open = !i_config_write_lock || (ul_q == UL_OPEN); // [RULE_14]

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `PWMC_RESP_OKAY;
            awaddr_q  <= 8'h00;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (o_s_axi_awready && i_s_axi_awvalid) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr;
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
                w_hold_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata[15:0];
                wstrb_q  <= i_s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= is_mapped(awaddr_q) ? `PWMC_RESP_OKAY : `PWMC_RESP_SLVERR;
            end else if (bvalid_q && i_s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign o_s_axi_arready = !rvalid_q;
    assign o_s_axi_rvalid  = rvalid_q;
    assign o_s_axi_rdata   = rdata_q;
    assign o_s_axi_rresp   = rresp_q;

    always_comb begin
        case ({i_s_axi_araddr[7:2], 2'b00})
            `PWMC_OFS_TBCTL:  rd_word = zext16({tbctl_q[15:13], pend_q, tbctl_q[11:0]});
            `PWMC_OFS_IOCTL:  rd_word = zext16(iocon_q);
            `PWMC_OFS_LEBCTL: rd_word = zext16(lebcon_q);
            `PWMC_OFS_LEBDLY: rd_word = zext16(lebdly_q);
            `PWMC_OFS_PERIOD: rd_word = zext16(period_q);
            `PWMC_OFS_ACTPER: rd_word = zext16(act_period_q);
            `PWMC_OFS_UNLOCK: rd_word = zext16({14'h0000, ul_q});
            `PWMC_OFS_TBCNT:  rd_word = zext16(tb_cnt_q);
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `PWMC_RESP_OKAY;
        end else if (o_s_axi_arready && i_s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= is_mapped(i_s_axi_araddr) ? `PWMC_RESP_OKAY : `PWMC_RESP_SLVERR;
        end else if (rvalid_q && i_s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // configuration registers; pending flag bit is hardware owned and not writable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tbctl_q  <= 16'h0000;
            iocon_q  <= `PWMC_IOCTL_RST;
            lebcon_q <= 16'h0000;
            lebdly_q <= 16'h0000;
            period_q <= 16'h0000;
        end else begin
            if (wr_tb) tbctl_q <= merge16(tbctl_q, wdata_q, wstrb_q, `PWMC_TBCTL_WMASK);
            if (wr_io && io_open) iocon_q <= merge16(iocon_q, wdata_q, wstrb_q, 16'hffff); // [RULE_14]
            if (wr_lc) lebcon_q <= merge16(lebcon_q, wdata_q, wstrb_q, `PWMC_LEBCTL_MASK);
            if (wr_ld) lebdly_q <= merge16(lebdly_q, wdata_q, wstrb_q, `PWMC_LEBDLY_MASK); // [RULE_16]
            if (wr_per) period_q <= per_new;
        end
    end

    // unlock opens exactly one io control write; a wrong key falls back to locked
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ul_q <= UL_LOCKED;
        end else begin
            case (ul_q)
                UL_LOCKED: if (wr_key && wdata_q == `PWMC_UNLOCK_KEY1) ul_q <= UL_KEY1; // [RULE_14]
                UL_KEY1:   if (do_wr) ul_q <= (wr_key && wdata_q == `PWMC_UNLOCK_KEY2) ?
                                              UL_OPEN : UL_LOCKED;
                UL_OPEN:   if (wr_io) ul_q <= UL_LOCKED;
                default:   ul_q <= UL_LOCKED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_ff1_q <= 1'b0;
            sync_ff2_q <= 1'b0;
            flt_ff1_q  <= 1'b0;
            flt_ff2_q  <= 1'b0;
            cl_ff1_q   <= 1'b0;
            cl_ff2_q   <= 1'b0;
        end else begin
            sync_ff1_q <= i_sync_input;
            sync_ff2_q <= sync_ff1_q;
            flt_ff1_q  <= i_fault_input;
            flt_ff2_q  <= flt_ff1_q;
            cl_ff1_q   <= i_current_limit_input;
            cl_ff2_q   <= cl_ff1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // time base, external sync and period update
    logic run, sync_act, sync_edge, ext_rst, boundary;
    assign run       = en && !(idle_halt && i_cpu_idle);                  // [RULE_01] [RULE_02]
    assign sync_act  = sync_ff2_q ^ pol;                                  // [RULE_05]
    assign sync_edge = sync_act && !sync_prev_q;
    assign ext_rst   = run && ext_en && sync_edge;                        // [RULE_07]
    assign boundary  = run && (ext_rst || tb_cnt_q >= act_period_q);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tb_cnt_q    <= 16'h0000;
            phase_q     <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_act;
            if (!en) begin
                tb_cnt_q <= 16'h0000;
                phase_q  <= 1'b0;
            end else if (boundary) begin
                tb_cnt_q <= 16'h0000;
                phase_q  <= !phase_q;
            end else if (run) begin
                tb_cnt_q <= tb_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_period_q <= 16'h0000;
            load_pend_q  <= 1'b0;
        end else if (wr_per && imm) begin
            act_period_q <= per_new;                                      // [RULE_04]
            load_pend_q  <= 1'b0;
        end else if (wr_per) begin
            load_pend_q <= 1'b1;
        end else if (boundary && load_pend_q) begin
            act_period_q <= period_q;                                     // [RULE_04]
            load_pend_q  <= 1'b0;
        end
    end

    // sync out carries an inverted idle level when polarity is active low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_out_q <= 1'b0;
        end else begin
            sync_out_q <= oen ? (boundary ^ pol) : 1'b0;                  // [RULE_05] [RULE_06]
        end
    end
    assign o_sync_output = sync_out_q;

    // an event arriving with the acknowledge still sets the flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= i_special_event || (pend_q && !i_special_event_ack);  // [RULE_03]
        end
    end
    assign o_special_event_irq = pend_q && special_event_irq_enable;                         // [RULE_03]

    ////////////////////////////////////////////////////////////////////////////////////////
    // blanking and fault qualification
    logic leb_busy, st_blank, flt_act, cl_act, leb_trig;
    assign leb_busy = leb_cnt_q != 12'h000;
    assign st_blank = (lebcon_q[5] && i_blank_select) || (lebcon_q[4] && !i_blank_select) // [RULE_17]
                   || (lebcon_q[3] && pins_q.high) || (lebcon_q[2] && !pins_q.high)     // [RULE_18]
                   || (lebcon_q[1] && pins_q.low) || (lebcon_q[0] && !pins_q.low);
    assign flt_act  = flt_ff2_q && !st_blank && !(lebcon_q[11] && leb_busy);    // [RULE_19]
    assign cl_act   = cl_ff2_q && !st_blank && !(lebcon_q[10] && leb_busy);     // [RULE_19]
    assign leb_trig = (lebcon_q[15] && pins_d.high && !pins_q.high)             // [RULE_15]
                   || (lebcon_q[14] && !pins_d.high && pins_q.high)
                   || (lebcon_q[13] && pins_d.low && !pins_q.low)
                   || (lebcon_q[12] && !pins_d.low && pins_q.low);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            leb_cnt_q <= 12'h000;
        end else if (leb_trig) begin
            leb_cnt_q <= lebdly_q[11:0];                                  // [RULE_15] [RULE_16]
        end else if (leb_busy) begin
            leb_cnt_q <= leb_cnt_q - 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // pin pair output: fault over current limit over override over generator
    logic h, l;
    always_comb begin
        case (pin_pair_mode)                                                       // [RULE_10]
            PM_COMPL:    begin h = i_gen_high; l = !i_gen_high; end
            PM_REDUND:   begin h = i_gen_high; l = i_gen_high; end
            PM_PUSHPULL: begin h = i_gen_high && !phase_q; l = i_gen_high && phase_q; end
            default:     begin h = 1'b0; l = 1'b0; end
        endcase
        if (ovr_h) h = iocon_q[7];                                        // [RULE_11]
        if (ovr_l) l = iocon_q[6];                                        // [RULE_11]
        if (cl_act) begin
            h = iocon_q[3];                                               // [RULE_12]
            l = iocon_q[2];
        end
        if (flt_act) begin
            h = iocon_q[5];                                               // [RULE_12]
            l = iocon_q[4];
        end
        if (!en) begin
            h = 1'b0;
            l = 1'b0;
        end
        pins_d.high    = h ^ high_pin_polarity;
        pins_d.low     = l ^ poll;
        pins_d.high_oe = en && high_pin_ownership;                                      // [RULE_01]
        pins_d.low_oe  = en && low_pin_ownership;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end
    assign o_pins = pins_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence leb_start_s;
        leb_trig && lebdly_q[11:0] != 12'h000;
    endsequence

    dis_pins_off_a: assert property (!en |=> !o_pins.high_oe && !o_pins.low_oe) // [RULE_01]
        else $error("pins driven while module disabled");
    idle_hold_a: assert property (en && idle_halt && i_cpu_idle |=> $stable(tb_cnt_q)) // [RULE_02]
        else $error("time base moved in idle halt");
    event_irq_a: assert property (i_special_event && special_event_irq_enable |=> pend_q && o_special_event_irq) // [RULE_03]
        else $error("special event not flagged");
    period_now_a: assert property (wr_per && imm |=> act_period_q == $past(per_new)) // [RULE_04]
        else $error("immediate period not loaded");
    sync_out_a: assert property (boundary && oen |=> o_sync_output == !$past(pol)) // [RULE_05]
        else $error("sync output level wrong");
    sync_off_a: assert property (!oen |=> !o_sync_output) // [RULE_06]
        else $error("sync output active while disabled");
    ext_sync_a: assert property (ext_rst |=> tb_cnt_q == 16'h0000) // [RULE_07]
        else $error("external sync did not restart time base");
    compl_pair_a: assert property (en && pin_pair_mode == PM_COMPL && !ovr_h && !ovr_l // [RULE_10]
        && !flt_act && !cl_act |=> (o_pins.high ^ $past(high_pin_polarity)) != (o_pins.low ^ $past(poll)))
        else $error("complementary pair not complementary");
    override_a: assert property (en && ovr_h && !flt_act && !cl_act // [RULE_11]
        |=> o_pins.high == $past(iocon_q[7] ^ high_pin_polarity))
        else $error("override level not driven");
    fault_force_a: assert property (en && flt_act |=> o_pins.low == $past(iocon_q[4] ^ poll)) // [RULE_12]
        else $error("fault data not driven");
    lock_hold_a: assert property (wr_io && !io_open |=> $stable(iocon_q)) // [RULE_14]
        else $error("locked io control written");
    leb_load_a: assert property (leb_start_s |=> leb_cnt_q == $past(lebdly_q[11:0]) // [RULE_15]
        ##1 leb_cnt_q == $past(leb_cnt_q) - 12'h001 || $past(leb_trig))
        else $error("blanking counter not started");
    leb_upper_a: assert property (lebdly_q[15:12] == 4'h0) // [RULE_16]
        else $error("blanking delay upper bits set");
    state_blank_a: assert property (st_blank |-> !flt_act && !cl_act) // [RULE_17]
        else $error("input seen during state blanking");
    leb_ignore_a: assert property (lebcon_q[11] && leb_busy |-> !flt_act) // [RULE_19]
        else $error("fault seen during leading edge blanking");
endmodule

// ===== verification/pwmc_stage.sv
// pwmc_stage: behavioural power stage hanging on the pin pair.
// assumes the bench commands the trips; pins come from pwmc_top.
`timescale 1ns/1ps
module pwmc_stage (
    input  pwmc_pkg::pwmc_pins_t i_pins,
    input  wire logic            i_trip_fault,
    input  wire logic            i_trip_limit,
    output wire logic            o_fault,
    output wire logic            o_limit
);
    import pwmc_pkg::*;
    assign o_fault = i_trip_fault;
    // overcurrent only shows while some leg really conducts
    assign o_limit = i_trip_limit & ((i_pins.high & i_pins.high_oe) | (i_pins.low & i_pins.low_oe));
endmodule

// ===== verification/pwm_output_control_blanking_bench.sv
// bench for pwmc_top with a power stage model on its pins.
// assumes the map header sits on the include path.
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwm_output_control_blanking_bench;
    import pwmc_pkg::*;
    logic i_clk, i_rst_n, i_cpu_idle, i_config_write_lock, i_special_event;
    logic i_special_event_ack, i_gen_high, i_blank_select, i_sync_input, trip_f, trip_c;
    logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic o_sync_output, o_special_event_irq, i_fault_input, i_current_limit_input;
    logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdv;
    logic [3:0]  i_s_axi_wstrb;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rsp;
    pwmc_pins_t  o_pins;
    int          err_count, tests_run;
    pwmc_top u_dut (.i_clk, .i_rst_n, .i_cpu_idle, .i_config_write_lock, .i_special_event,
        .i_special_event_ack, .i_gen_high, .i_blank_select, .i_sync_input, .i_fault_input,
        .i_current_limit_input, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
        .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid,
        .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
        .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .o_pins,
        .o_sync_output, .o_special_event_irq);
    pwmc_stage u_stage (.i_pins(o_pins), .i_trip_fault(trip_f), .i_trip_limit(trip_c),
        .o_fault(i_fault_input), .o_limit(i_current_limit_input));
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compared %0d, mismatched %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // handshakes judged at the falling edge, where ready has settled
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ta, tw, tb;
        int n;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_awaddr <= a;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_wdata <= {16'h0000, d};
        for (n = 0; n < 40; n++) begin
            @(negedge i_clk);
            ta = i_s_axi_awvalid & o_s_axi_awready;
            tw = i_s_axi_wvalid & o_s_axi_wready;
            tb = o_s_axi_bvalid;
            rsp = o_s_axi_bresp;
            @(posedge i_clk);
            if (ta) i_s_axi_awvalid <= 1'b0;
            if (tw) i_s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        if (n == 40) err_count++;
        if (n == 40) summarize();
        chk({30'h0000_0000, rsp}, `PWMC_RESP_OKAY);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic ta, tv;
        int n;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_araddr <= a;
        for (n = 0; n < 40; n++) begin
            @(negedge i_clk);
            ta = i_s_axi_arvalid & o_s_axi_arready;
            tv = o_s_axi_rvalid;
            rdv = o_s_axi_rdata;
            rsp = o_s_axi_rresp;
            @(posedge i_clk);
            if (ta) i_s_axi_arvalid <= 1'b0;
            if (tv) break;
        end
        if (n == 40) err_count++;
        if (n == 40) summarize();
        chk(rdv, e);
        chk({30'h0000_0000, rsp}, (a[7:5] != 3'h0) ? `PWMC_RESP_SLVERR : `PWMC_RESP_OKAY);
    endtask
    task automatic wio(input logic [15:0] d);
        wr(`PWMC_OFS_UNLOCK, `PWMC_UNLOCK_KEY1);
        wr(`PWMC_OFS_UNLOCK, `PWMC_UNLOCK_KEY2);
        wr(`PWMC_OFS_IOCTL, d);
    endtask
    task automatic pin(input int n, input logic [3:0] e);
        wt(n);
        @(negedge i_clk);
        chk(32'(o_pins), {28'h000_0000, e});
        @(posedge i_clk);
    endtask
    task automatic ev;
        i_special_event <= 1'b1;
        wt(1);
        i_special_event <= 1'b0;
        wt(2);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rc(`PWMC_OFS_TBCTL, 32'h0000_0000);
        rc(`PWMC_OFS_IOCTL, 32'h0000_c000);
        rc(`PWMC_OFS_LEBCTL, 32'h0000_0000);
        rc(8'h20, 32'h0000_0000);
        wr(`PWMC_OFS_LEBDLY, 16'hffff);
        rc(`PWMC_OFS_LEBDLY, 32'h0000_0fff);
        wr(`PWMC_OFS_LEBCTL, 16'hffff);
        rc(`PWMC_OFS_LEBCTL, 32'h0000_fc3f);
        wr(`PWMC_OFS_IOCTL, 16'h0000);
        rc(`PWMC_OFS_IOCTL, 32'h0000_c000);
        wr(`PWMC_OFS_LEBCTL, 16'h0000);
        $display("regs done");
    endtask
    task automatic t_pins;
        wio(16'hc39c);
        rc(`PWMC_OFS_IOCTL, 32'h0000_c39c);
        pin(1, 4'h0);
        wr(`PWMC_OFS_TBCTL, 16'h8000);
        pin(2, 4'hb);
        trip_f <= 1'b1;
        pin(5, 4'h7);
        trip_c <= 1'b1;
        pin(5, 4'h7);
        trip_f <= 1'b0;
        pin(5, 4'hf);
        trip_c <= 1'b0;
        pin(5, 4'hb);
        wr(`PWMC_OFS_TBCTL, 16'h0000);
        pin(2, 4'h0);
        $display("pins done");
    endtask
    task automatic t_irq;
        wr(`PWMC_OFS_TBCTL, 16'h0800);
        ev();
        chk({31'h0000_0000, o_special_event_irq}, 32'h0000_0001);
        rc(`PWMC_OFS_TBCTL, 32'h0000_1800);
        i_special_event_ack <= 1'b1;
        wt(1);
        i_special_event_ack <= 1'b0;
        wt(2);
        chk({31'h0000_0000, o_special_event_irq}, 32'h0000_0000);
        wr(`PWMC_OFS_TBCTL, 16'h0000);
        ev();
        chk({31'h0000_0000, o_special_event_irq}, 32'h0000_0000);
        rc(`PWMC_OFS_TBCTL, 32'h0000_1000);
        $display("irq done");
    endtask
    task automatic t_leb;
        wr(`PWMC_OFS_LEBDLY, 16'h0014);
        wr(`PWMC_OFS_LEBCTL, 16'h8800);
        wr(`PWMC_OFS_TBCTL, 16'h8100);
        trip_f <= 1'b1;
        pin(8, 4'hb);
        pin(20, 4'h7);
        chk({31'h0000_0000, o_sync_output}, 32'h0000_0001);
        trip_f <= 1'b0;
        wr(`PWMC_OFS_TBCTL, 16'h0000);
        $display("blanking done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, i_cpu_idle, i_special_event, i_special_event_ack, i_blank_select} = '0;
        {i_sync_input, trip_f, trip_c, i_s_axi_awvalid, i_s_axi_wvalid} = '0;
        {i_s_axi_arvalid, i_s_axi_awaddr, i_s_axi_araddr} = '0;
        {i_s_axi_bready, i_s_axi_rready} = 2'b11;
        {i_config_write_lock, i_gen_high, i_s_axi_wstrb, i_s_axi_wdata} = {6'h3f, 32'h0000_0000};
        err_count = 0;
        tests_run = 0;
        wt(12);
        i_rst_n <= 1'b1;
        t_regs();
        t_pins();
        t_irq();
        t_leb();
        summarize();
    end
endmodule
